// ### rtl/cls_stopwatch.sv
// per-channel comma latency stopwatch with management access and pin trigger
//
// Behaviour
// - two start and two stop points per channel, chosen by config bits
// - only K28.1, K28.5, K28.7 with control flag set count as commas
// - first start-point comma starts counting, first stop-point comma halts it
// - every channel has its own independent stopwatch
// - result is a 20-bit count readable over management
// - result saturates at 0xFFFFF instead of wrapping
// - one result is held and not replaced until the host reads it
// - result reads zero if counting never began
// - a transition on the trigger pin may start and stop the stopwatch
// - fast clock is bit rate over 8, 4, 2 or 1 by serdes rate
// - fast clock further divided by 1, 2, 4 or 8 by config
// - counting clock always comes from the channel measured
// - recovered byte clock, bit rate over 20, is an alternative source
// - resolution is one period of the selected counting clock
// - registers reached by two-wire management frames, address from five straps
module cls_stopwatch #(
  parameter int unsigned NUM_CH = 4
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_mdc,
  input  wire logic                        i_mdio_in,
  output logic                             o_mdio_out,
  output logic                             o_mdio_oe,
  input  wire logic [4:0]                  i_port_addr_straps,
  input  wire logic [NUM_CH-1:0][1:0]      i_start_ctrl,
  input  wire logic [NUM_CH-1:0][1:0][7:0] i_start_data,
  input  wire logic [NUM_CH-1:0][1:0]      i_stop_ctrl,
  input  wire logic [NUM_CH-1:0][1:0][7:0] i_stop_data,
  input  wire logic [NUM_CH-1:0]           i_ser_tick,
  input  wire logic [NUM_CH-1:0]           i_byte_tick,
  output logic [NUM_CH-1:0]                o_running,
  output logic [NUM_CH-1:0]                o_done
);
  // five address bits hold a 3-bit channel and a 2-bit register index
  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
    $error("NUM_CH must lie between 1 and 8");
  end

  typedef enum logic [1:0] {S_ARMED, S_RUN, S_DONE} cls_state_t;

  // pin synchronisers: mdc, mdio and the five straps
  localparam int unsigned NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, filt_q, filt_old_q;
  assign pin_raw = {i_port_addr_straps, i_mdio_in, i_mdc};

  for (genvar p = 0; p < NPIN; p++) begin : g_sync
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        s1_q[p] <= 1'b0;
        s2_q[p] <= 1'b0;
        s3_q[p] <= 1'b0;
        filt_q[p] <= 1'b0;
        filt_old_q[p] <= 1'b0;
      end else begin
        s1_q[p] <= pin_raw[p];
        s2_q[p] <= s1_q[p];
        s3_q[p] <= s2_q[p];
        filt_old_q[p] <= filt_q[p];
        // a change is believed only once two later stages agree
        if (s2_q[p] == s3_q[p]) begin
          filt_q[p] <= s3_q[p];
        end
      end
    end
  end

  wire       mdc_rise = filt_q[0] && !filt_old_q[0];
  wire       mdio_in  = filt_q[1];
  wire [4:0] strap_now = filt_q[6:2];
  wire       trig_lvl  = strap_now[cls_pkg::TRIG_STRAP_BIT];
  wire       trig_old  = filt_old_q[2 + cls_pkg::TRIG_STRAP_BIT];

  // straps are sampled once, after the synchronisers have filled
  logic [2:0] strap_wait_q;
  logic       strap_done_q;
  logic [4:0] port_addr_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_wait_q <= 3'h0;
      strap_done_q <= 1'b0;
      port_addr_q <= 5'h00;
    end else if (!strap_done_q) begin
      strap_wait_q <= strap_wait_q + 3'h1;
      // one edge past the filter fill, so the capture and the trigger history agree
      if (strap_wait_q == cls_pkg::STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        port_addr_q <= strap_now;
      end
    end
  end

  // the trigger shares its pin with a strap, so only post-capture edges count
  wire pin_ev = strap_done_q && (trig_lvl != trig_old);

  cls_mgmt_if mgmt ();

  cls_mdio_frame u_frame (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_mdc_rise  (mdc_rise && strap_done_q),
    .i_mdio_in   (mdio_in),
    .i_port_addr (port_addr_q),
    .o_mdio_out  (o_mdio_out),
    .o_mdio_oe   (o_mdio_oe),
    .bus         (mgmt.frame)
  );

  wire [2:0] acc_ch  = mgmt.reg_addr[4:2];
  wire [1:0] acc_reg = mgmt.reg_addr[1:0];

  logic [NUM_CH-1:0][15:0] cfg_a;
  logic [NUM_CH-1:0][19:0] cnt_a;
  logic [NUM_CH-1:0][1:0]  stat_a;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [15:0] cfg_q;
    logic [19:0] cnt_q, cnt_d;
    logic [5:0]  div_q, div_d;
    cls_state_t  st_q, st_d;
    logic        start_hit, stop_hit;

    wire       sel_ch    = (acc_ch == 3'(c));
    wire       cfg_wr    = mgmt.wr_stb && sel_ch && (acc_reg == cls_pkg::REG_CFG);
    wire       res_read  = mgmt.rd_stb && sel_ch && (acc_reg == cls_pkg::REG_RES_LO);
    wire       start_sel = cfg_q[cls_pkg::CFG_START_SEL];
    wire       stop_sel  = cfg_q[cls_pkg::CFG_STOP_SEL];
    wire [1:0] div_sel   = cfg_q[cls_pkg::CFG_DIV_LSB +: 2];
    wire       byte_src  = cfg_q[cls_pkg::CFG_BYTE_SRC];
    wire [1:0] rate      = cfg_q[cls_pkg::CFG_RATE_LSB +: 2];
    wire       pin_mode  = cfg_q[cls_pkg::CFG_PIN_MODE];

    // point selection happens before detection
    cls_comma_det u_start_det (
      .i_ctrl (i_start_ctrl[c][start_sel]),
      .i_data (i_start_data[c][start_sel]),
      .o_hit  (start_hit)
    );
    cls_comma_det u_stop_det (
      .i_ctrl (i_stop_ctrl[c][stop_sel]),
      .i_data (i_stop_data[c][stop_sel]),
      .o_hit  (stop_hit)
    );

    wire start_ev = pin_mode ? pin_ev : start_hit;
    wire stop_ev  = pin_mode ? pin_ev : stop_hit;

    // rate divide then user divide, as one power-of-two count
    wire [2:0] div_shift = 3'(cls_pkg::RATE_SHIFT_MAX - {1'b0, rate}) + {1'b0, div_sel};
    wire [5:0] div_lim   = 6'((7'h01 << div_shift) - 7'h01);
    wire       hs_tick   = i_ser_tick[c] && (div_q == div_lim);
    // only this channel's own ticks ever reach its counter
    wire       meas_tick = byte_src ? i_byte_tick[c] : hs_tick;
    wire       at_sat    = (cnt_q == cls_pkg::RES_SAT);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        cfg_q <= cls_pkg::CFG_RESET;
      end else if (cfg_wr) begin
        cfg_q <= mgmt.wr_data;
      end
    end

    // divider restarts with the measurement, so error stays within one period
    always_comb begin
      div_d = div_q;
      if (st_q != S_RUN) begin
        div_d = 6'h00;
      end else if (i_ser_tick[c]) begin
        div_d = (div_q == div_lim) ? 6'h00 : div_q + 6'h01;
      end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        div_q <= 6'h00;
      end else begin
        div_q <= div_d;
      end
    end

    // a read wins over any event in its cycle: release and re-arm
    always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      if (res_read) begin
        st_d = S_ARMED;
        cnt_d = cls_pkg::RES_ZERO;
      end else begin
        case (st_q)
          S_ARMED: begin
            if (start_ev) begin
              st_d = S_RUN;
              cnt_d = cls_pkg::RES_ZERO;
            end
          end
          S_RUN: begin
            if (stop_ev) begin
              st_d = S_DONE;
            end else if (meas_tick && !at_sat) begin
              cnt_d = cnt_q + 20'h0_0001;
            end
          end
          S_DONE: begin
            // held until read, later commas are ignored
            st_d = S_DONE;
          end
          default: st_d = S_ARMED;
        endcase
      end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        st_q <= S_ARMED;
        cnt_q <= cls_pkg::RES_ZERO;
      end else begin
        st_q <= st_d;
        cnt_q <= cnt_d;
      end
    end

    assign cfg_a[c]  = cfg_q;
    assign cnt_a[c]  = cnt_q;
    assign stat_a[c] = {st_q == S_DONE, st_q == S_RUN};
    assign o_running[c] = (st_q == S_RUN);
    assign o_done[c]    = (st_q == S_DONE);
  end

  // read multiplexer; unmapped channels and registers read zero
  logic [15:0] rd_mux;
  wire         ch_ok = ({1'b0, acc_ch} < 4'(NUM_CH));

  always_comb begin
    rd_mux = 16'h0000;
    if (ch_ok) begin
      case (acc_reg)
        cls_pkg::REG_CFG:    rd_mux = cfg_a[acc_ch];
        cls_pkg::REG_RES_HI: rd_mux = {12'h000, cnt_a[acc_ch][19:16]};
        cls_pkg::REG_RES_LO: rd_mux = cnt_a[acc_ch][15:0];
        cls_pkg::REG_STAT:   rd_mux = {14'h0000, stat_a[acc_ch]};
        default:             rd_mux = 16'h0000;
      endcase
    end
  end
  assign mgmt.rd_data = rd_mux;
endmodule

// ### common/cls_pkg.sv
// shared constants for the comma latency stopwatch
package cls_pkg;
  localparam int unsigned RES_W         = 20;
  localparam logic [19:0] RES_SAT       = 20'hf_ffff;
  localparam logic [19:0] RES_ZERO      = 20'h0_0000;
  localparam logic [7:0]  K28_1_DATA    = 8'h3c;
  localparam logic [7:0]  K28_5_DATA    = 8'hbc;
  localparam logic [7:0]  K28_7_DATA    = 8'hfc;
  // register index inside a channel's group of four
  localparam logic [1:0]  REG_CFG       = 2'h0;
  localparam logic [1:0]  REG_RES_HI    = 2'h1;
  localparam logic [1:0]  REG_RES_LO    = 2'h2;
  localparam logic [1:0]  REG_STAT      = 2'h3;
  localparam int unsigned CFG_START_SEL = 0;
  localparam int unsigned CFG_STOP_SEL  = 1;
  localparam int unsigned CFG_DIV_LSB   = 2;
  localparam int unsigned CFG_BYTE_SRC  = 4;
  localparam int unsigned CFG_RATE_LSB  = 5;
  localparam int unsigned CFG_PIN_MODE  = 7;
  localparam logic [15:0] CFG_RESET     = 16'h0000;
  // rate code 0 full, 1 half, 2 quarter, 3 eighth: divide by 2^(3-code)
  localparam logic [2:0]  RATE_SHIFT_MAX = 3'h3;
  localparam logic [5:0]  MDIO_PRE_LEN  = 6'h20;
  localparam logic [1:0]  MDIO_OP_READ  = 2'h2;
  localparam logic [1:0]  MDIO_OP_WRITE = 2'h1;
  localparam logic [4:0]  MDIO_HDR_LAST = 5'h0b;
  localparam logic [4:0]  MDIO_DAT_LAST = 5'h0f;
  localparam logic [2:0]  STRAP_WAIT    = 3'h4;
  localparam int unsigned TRIG_STRAP_BIT = 1;
endpackage

// ### common/cls_mgmt_if.sv
// register access path between the management frame engine and the channels
interface cls_mgmt_if;
  logic [4:0]  reg_addr;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic        rd_stb;
  logic [15:0] rd_data;
  modport frame (output reg_addr, output wr_stb, output wr_data, output rd_stb,
                 input rd_data);
  modport regs  (input reg_addr, input wr_stb, input wr_data, input rd_stb,
                 output rd_data);
endinterface

// ### rtl/cls_comma_det.sv
// recognises the three comma-bearing control characters
module cls_comma_det (
  input  wire logic       i_ctrl,
  input  wire logic [7:0] i_data,
  output logic            o_hit
);
  wire is_k1 = (i_data == cls_pkg::K28_1_DATA);
  wire is_k5 = (i_data == cls_pkg::K28_5_DATA);
  wire is_k7 = (i_data == cls_pkg::K28_7_DATA);
  // a data byte with the same value is not a comma
  assign o_hit = i_ctrl && (is_k1 || is_k5 || is_k7);
endmodule

// ### rtl/cls_mdio_frame.sv
// management frame engine: preamble, start, opcode, addresses, turnaround, data
module cls_mdio_frame (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic       i_mdc_rise,
  input  wire logic       i_mdio_in,
  input  wire logic [4:0] i_port_addr,
  output logic            o_mdio_out,
  output logic            o_mdio_oe,
  cls_mgmt_if.frame       bus
);
  typedef enum logic [2:0] {M_IDLE, M_ST, M_HDR, M_TA, M_DATA} cls_mstate_t;
  cls_mstate_t st_q;
  logic [5:0]  pre_q;
  logic [4:0]  cnt_q;
  logic [10:0] hdr_q;
  logic [15:0] sh_q;
  logic        act_q, rd_q, rd_stb_q, wr_stb_q, out_q, oe_q;
  logic [4:0]  addr_q;
  logic [15:0] wdat_q;

  wire [11:0] hdr_full = {hdr_q, i_mdio_in};
  wire        hit      = (hdr_full[9:5] == i_port_addr);
  wire        is_rd    = (hdr_full[11:10] == cls_pkg::MDIO_OP_READ);
  wire        is_wr    = (hdr_full[11:10] == cls_pkg::MDIO_OP_WRITE);
  wire        pre_ok   = (pre_q == cls_pkg::MDIO_PRE_LEN);
  // only an answered read ever moves the data output off its idle level
  wire        answer   = act_q && rd_q;

  assign bus.reg_addr = addr_q;
  assign bus.rd_stb   = rd_stb_q;
  assign bus.wr_stb   = wr_stb_q;
  assign bus.wr_data  = wdat_q;
  assign o_mdio_out   = out_q;
  assign o_mdio_oe    = oe_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= M_IDLE;
      pre_q <= 6'h00;
      cnt_q <= 5'h00;
      hdr_q <= 11'h000;
      sh_q <= 16'h0000;
      act_q <= 1'b0;
      rd_q <= 1'b0;
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      out_q <= 1'b1;
      oe_q <= 1'b0;
      addr_q <= 5'h00;
      wdat_q <= 16'h0000;
    end else begin
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      // the read word is caught once, right after the address is known
      if (rd_stb_q) begin
        sh_q <= bus.rd_data;
      end
      if (i_mdc_rise) begin
        case (st_q)
          M_IDLE: begin
            if (i_mdio_in) begin
              pre_q <= pre_ok ? pre_q : pre_q + 6'h01;
            end else begin
              st_q <= pre_ok ? M_ST : M_IDLE;
              pre_q <= 6'h00;
            end
          end
          M_ST: begin
            st_q <= i_mdio_in ? M_HDR : M_IDLE;
            cnt_q <= 5'h00;
          end
          M_HDR: begin
            hdr_q <= hdr_full[10:0];
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == cls_pkg::MDIO_HDR_LAST) begin
              st_q <= M_TA;
              cnt_q <= 5'h00;
              addr_q <= hdr_full[4:0];
              act_q <= hit && (is_rd || is_wr);
              rd_q <= is_rd;
              rd_stb_q <= hit && is_rd;
            end
          end
          M_TA: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h00) begin
              oe_q <= answer;
              out_q <= !answer;
            end else begin
              st_q <= M_DATA;
              cnt_q <= 5'h00;
              out_q <= answer ? sh_q[15] : 1'b1;
              sh_q <= {sh_q[14:0], 1'b0};
            end
          end
          M_DATA: begin
            cnt_q <= cnt_q + 5'h01;
            out_q <= answer ? sh_q[15] : 1'b1;
            sh_q <= rd_q ? {sh_q[14:0], 1'b0} : {sh_q[14:0], i_mdio_in};
            if (cnt_q == cls_pkg::MDIO_DAT_LAST) begin
              st_q <= M_IDLE;
              oe_q <= 1'b0;
              out_q <= 1'b1;
              wr_stb_q <= act_q && !rd_q;
              wdat_q <= {sh_q[14:0], i_mdio_in};
            end
          end
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end
endmodule

// ### tb/cls_mdio_host.sv
// management host model: clause-22 style frames with a released line on reads
module cls_mdio_host #(
  parameter logic [4:0] PHY_ADDR = 5'h05
) (
  input  wire logic i_clock,
  input  wire logic i_mdio,
  output logic      o_mdc,
  output logic      o_mdio,
  output logic      o_mdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_mdc     = 1'b0;
    o_mdio    = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // six clocks per phase keeps well clear of the three-clock minimum
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] frame;
    frame = {32'hffff_ffff, 2'b01, op, PHY_ADDR, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      // on a read the line is let go for turnaround and data; the pull-up takes it
      o_mdio_oe = !(op == cls_pkg::MDIO_OP_READ && i < 18);
      o_mdio    = frame[i];
      repeat (6) @(posedge i_clock);
      #1 o_mdc = 1'b1;
      if (i < 16) begin
        rd[i] = i_mdio;
      end
      repeat (6) @(posedge i_clock);
      #1 o_mdc = 1'b0;
    end
    o_mdio_oe = 1'b0;
  endtask
endmodule

// ### tb/cls_stopwatch_asserts.sv
// port-level assertions for the stopwatch
module cls_stopwatch_asserts #(
  parameter int unsigned NUM_CH = 4
) (
  input wire logic                        i_clock,
  input wire logic                        i_reset_n,
  input wire logic                        i_mdc,
  input wire logic                        o_mdio_out,
  input wire logic                        o_mdio_oe,
  input wire logic [4:0]                  i_port_addr_straps,
  input wire logic [NUM_CH-1:0][1:0]      i_start_ctrl,
  input wire logic [NUM_CH-1:0][1:0][7:0] i_start_data,
  input wire logic [NUM_CH-1:0][1:0]      i_stop_ctrl,
  input wire logic [NUM_CH-1:0][1:0][7:0] i_stop_data,
  input wire logic [NUM_CH-1:0]           o_running,
  input wire logic [NUM_CH-1:0]           o_done
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic       mdc_q;
  logic       pin_q;
  logic [5:0] mdc_age_q;
  logic [5:0] pin_age_q;
  function automatic logic cls_comma(input logic c, input logic [7:0] d);
    return c && (d == cls_pkg::K28_1_DATA || d == cls_pkg::K28_5_DATA ||
                 d == cls_pkg::K28_7_DATA);
  endfunction
  // pin and management clock pass synchronisers, so their effects trail by some cycles
  wire mdc_busy  = mdc_age_q <= 6'h0c;
  wire pin_busy  = pin_age_q <= 6'h0c;
  wire start_hit = cls_comma(i_start_ctrl[0][0], i_start_data[0][0]) |
                   cls_comma(i_start_ctrl[0][1], i_start_data[0][1]);
  wire stop_hit  = cls_comma(i_stop_ctrl[0][0], i_stop_data[0][0]) |
                   cls_comma(i_stop_ctrl[0][1], i_stop_data[0][1]);
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mdc_q     <= 1'b0;
      pin_q     <= 1'b0;
      mdc_age_q <= 6'h3f;
      pin_age_q <= 6'h3f;
    end else begin
      mdc_q     <= i_mdc;
      pin_q     <= i_port_addr_straps[1];
      mdc_age_q <= (mdc_q != i_mdc) ? 6'h00 : mdc_age_q + 6'(mdc_age_q != 6'h3f);
      pin_age_q <= (pin_q != i_port_addr_straps[1]) ? 6'h00 : pin_age_q + 6'(pin_age_q != 6'h3f);
    end
  end
  sequence quiet_run;
    o_running[0] && !stop_hit && !mdc_busy && !pin_busy;
  endsequence
  sequence quiet_done;
    o_done[0] && !mdc_busy;
  endsequence
  excl_state_a: assert property ((o_running & o_done) == '0)
    else $error("channel both running and done");
  start_cause_a: assert property ($rose(o_running[0]) |-> $past(start_hit) || pin_busy)
    else $error("counting began without a start event");
  stop_cause_a: assert property ($rose(o_done[0]) |->
    $past(o_running[0]) && ($past(stop_hit) || pin_busy))
    else $error("result held without a stop event");
  run_hold_a: assert property (quiet_run |=> o_running[0])
    else $error("counting ended without cause");
  done_hold_a: assert property (quiet_done |=> o_done[0])
    else $error("held result dropped without a read");
  mdio_idle_a: assert property (!o_mdio_oe |-> o_mdio_out)
    else $error("data output not idle high");
  oe_start_a: assert property ($rose(o_mdio_oe) |-> !o_mdio_out && mdc_busy)
    else $error("bad start of read answer");
  done_clear_a: assert property ($fell(o_done[0]) |-> mdc_busy)
    else $error("result released without management access");
endmodule

bind cls_stopwatch cls_stopwatch_asserts #(.NUM_CH(NUM_CH)) u_chk (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_mdc(i_mdc), .o_mdio_out(o_mdio_out),
  .o_mdio_oe(o_mdio_oe), .i_port_addr_straps(i_port_addr_straps),
  .i_start_ctrl(i_start_ctrl), .i_start_data(i_start_data), .i_stop_ctrl(i_stop_ctrl),
  .i_stop_data(i_stop_data), .o_running(o_running), .o_done(o_done)
);

// ### tb/cls_stopwatch_bench.sv
// self-checking bench for the comma latency stopwatch
module cls_stopwatch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NCH    = 2;
  localparam logic [4:0]  PHY    = 5'h05;
  localparam logic [7:0]  KD [3] = '{cls_pkg::K28_1_DATA, cls_pkg::K28_5_DATA,
                                     cls_pkg::K28_7_DATA};
  logic                     clock = 1'b0;
  logic                     reset_n = 1'b0;
  logic                     mdc;
  logic                     host_mdio;
  logic                     host_oe;
  logic                     dut_mdio;
  logic                     dut_oe;
  logic [4:0]               straps = PHY;
  logic [NCH-1:0][1:0]      st_c = '0;
  logic [NCH-1:0][1:0]      sp_c = '0;
  logic [NCH-1:0][1:0][7:0] st_d = '0;
  logic [NCH-1:0][1:0][7:0] sp_d = '0;
  logic [NCH-1:0]           ser = '0;
  logic [NCH-1:0]           byt = '0;
  logic [NCH-1:0]           run;
  logic [NCH-1:0]           done;
  int                       err_count = 0;
  int                       n_compared = 0;
  int                       cyc = 0;
  wire                      mdio = dut_oe ? dut_mdio : (host_oe ? host_mdio : 1'b1);

  always #4 clock = ~clock;

  cls_stopwatch #(.NUM_CH(NCH)) dut (
    .i_clock(clock), .i_reset_n(reset_n), .i_mdc(mdc), .i_mdio_in(mdio),
    .o_mdio_out(dut_mdio), .o_mdio_oe(dut_oe), .i_port_addr_straps(straps),
    .i_start_ctrl(st_c), .i_start_data(st_d), .i_stop_ctrl(sp_c), .i_stop_data(sp_d),
    .i_ser_tick(ser), .i_byte_tick(byt), .o_running(run), .o_done(done)
  );
  cls_mdio_host #(.PHY_ADDR(PHY)) host (
    .i_clock(clock), .i_mdio(mdio), .o_mdc(mdc), .o_mdio(host_mdio), .o_mdio_oe(host_oe)
  );

  task automatic end_sim;
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr_cfg(input int ch, input logic [15:0] d);
    logic [15:0] r;
    host.xfer(cls_pkg::MDIO_OP_WRITE, 5'(ch * 4) + 5'(cls_pkg::REG_CFG), d, r);
  endtask
  task automatic rd_res(input int ch, output logic [19:0] res);
    logic [15:0] hi;
    logic [15:0] lo;
    host.xfer(cls_pkg::MDIO_OP_READ, 5'(ch * 4) + 5'(cls_pkg::REG_RES_HI), 16'h0000, hi);
    host.xfer(cls_pkg::MDIO_OP_READ, 5'(ch * 4) + 5'(cls_pkg::REG_RES_LO), 16'h0000, lo);
    res = {hi[3:0], lo};
  endtask
  // one character for one cycle on a start point, or a stop point when stop is set
  task automatic send(input int ch, input bit stop, input int pt, input logic c,
                      input logic [7:0] d);
    if (stop) begin
      sp_c[ch][pt] = c;
      sp_d[ch][pt] = d;
    end else begin
      st_c[ch][pt] = c;
      st_d[ch][pt] = d;
    end
    step(1);
    sp_c[ch][pt] = 1'b0;
    st_c[ch][pt] = 1'b0;
  endtask
  task automatic tick(input int ch, input bit fast, input int n);
    ser[ch] = fast;
    byt[ch] = !fast;
    step(n);
    ser[ch] = 1'b0;
    byt[ch] = 1'b0;
  endtask

  task automatic sc_reset;
    logic [15:0] cfg;
    logic [19:0] res;
    check(20'({run, done}), 20'h0_0000);
    host.xfer(cls_pkg::MDIO_OP_READ, 5'(cls_pkg::REG_CFG), 16'h0000, cfg);
    check(20'(cfg), 20'(cls_pkg::CFG_RESET));
    rd_res(1, res);
    check(res, cls_pkg::RES_ZERO);
  endtask
  task automatic sc_commas;
    logic [19:0] res;
    int          sel;
    int          psel;
    int          n;
    for (int k = 0; k < 3; k++) begin
      sel = k % 2;
      psel = k / 2;
      n = 9 + 7 * k;
      wr_cfg(0, 16'(sel) | 16'(psel << 1) | (16'h0001 << cls_pkg::CFG_BYTE_SRC));
      send(0, 0, sel, 1'b0, KD[k]);
      send(0, 0, sel, 1'b1, 8'h1c);
      send(0, 0, 1 - sel, 1'b1, KD[k]);
      check(20'(run), 20'h0_0000);
      send(0, 0, sel, 1'b1, KD[k]);
      check(20'(run), 20'h0_0001);
      tick(0, 0, n);
      send(0, 1, 1 - psel, 1'b1, KD[k]);
      check(20'(run), 20'h0_0001);
      send(0, 1, psel, 1'b1, KD[k]);
      check(20'({run, done}), 20'h0_0001);
      tick(0, 0, 4);
      send(0, 0, sel, 1'b1, KD[k]);
      check(20'({run, done}), 20'h0_0001);
      rd_res(0, res);
      check(res, 20'(n));
      check(20'(done), 20'h0_0000);
    end
  endtask
  task automatic sc_divide;
    logic [19:0] res;
    int          e;
    logic        ok;
    for (int r = 0; r < 4; r++) begin
      // heavier division at the higher rates, as a host must for long intervals
      wr_cfg(r % 2, 16'(r << cls_pkg::CFG_RATE_LSB) |
             16'((3 - r) << cls_pkg::CFG_DIV_LSB));
      send(r % 2, 0, 0, 1'b1, KD[1]);
      tick(r % 2, 1, 256);
      send(r % 2, 1, 0, 1'b1, KD[2]);
      rd_res(r % 2, res);
      e = 256 >> (6 - 2 * r);
      ok = (res + 20'h0_0001 >= 20'(e)) && (res <= 20'(e + 1));
      check(20'(ok), 20'h0_0001);
    end
  endtask
  task automatic sc_pin;
    logic [19:0] res;
    for (int ch = 0; ch < 2; ch++) begin
      wr_cfg(ch, (16'h0001 << cls_pkg::CFG_PIN_MODE) | (16'h0001 << cls_pkg::CFG_BYTE_SRC));
    end
    straps[1] = 1'b1;
    step(12);
    check(20'(run), 20'h0_0003);
    tick(0, 0, 20);
    straps[1] = 1'b0;
    step(12);
    check(20'(done), 20'h0_0003);
    rd_res(0, res);
    check(res, 20'h0_0014);
    rd_res(1, res);
    check(res, 20'h0_0000);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      $display("ERROR %0t: run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
    step(12);
    sc_reset();
    sc_commas();
    sc_divide();
    sc_pin();
    end_sim();
  end
endmodule
